// [hw/dbc_pkg.sv]
// Shared constants and types for the debug event and comparator A block.
package dbc_pkg;

   // ************************************************************
   // Register indices; the byte address is four times the index.
   // ************************************************************
   localparam logic [9:0] IDX_SESSION_CTRL = 10'h100;
   localparam logic [9:0] IDX_MAPPING      = 10'h101;
   localparam logic [9:0] IDX_EVENT_FLAGS  = 10'h10A;
   localparam logic [9:0] IDX_SEQ_STATUS   = 10'h10B;
   localparam logic [9:0] IDX_CMPA_CTRL    = 10'h110;
   localparam logic [9:0] IDX_CMPA_ADDR_HI = 10'h115;
   localparam logic [9:0] IDX_CMPA_ADDR_MD = 10'h116;
   localparam logic [9:0] IDX_CMPA_ADDR_LO = 10'h117;
   localparam logic [9:0] IDX_CMPA_DATA0   = 10'h118;
   localparam logic [9:0] IDX_CMPA_DATA3   = 10'h11B;
   localparam logic [9:0] IDX_CMPA_MASK0   = 10'h11C;
   localparam logic [9:0] IDX_CMPA_MASK3   = 10'h11F;

   // ************************************************************
   // Field positions and values after reset.
   // ************************************************************
   localparam int BIT_ARM          = 0;
   localparam int BIT_TRIGGER_FLAG = 6;
   localparam int BIT_EXT_FLAG     = 4;
   localparam int BIT_DATA_INV     = 6;
   localparam int BIT_INSTRUCTION_SELECT_SEL     = 5;
   localparam int BIT_DIR_VALUE    = 3;
   localparam int BIT_DIR_ENABLE   = 2;
   localparam int BIT_CMP_ENABLE   = 0;
   localparam logic [7:0]  RESET_BYTE = 8'h00;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // ************************************************************
   // Sequencer field codes and comparator mapping codes.
   // ************************************************************
   localparam logic [2:0] SSF_DISARMED = 3'h0;
   localparam logic [2:0] SSF_STATE1   = 3'h1;
   localparam logic [2:0] SSF_STATE2   = 3'h2;
   localparam logic [2:0] SSF_STATE3   = 3'h3;
   localparam logic [2:0] SSF_FINAL    = 3'h4;
   localparam logic [1:0] MAP_DIRECT   = 2'h0;
   localparam logic [1:0] MAP_OUTSIDE  = 2'h2;

   // Sequencer states, one-hot.
   typedef enum logic [4:0] {
      SEQ_DISARMED = 5'h01,
      SEQ_STATE1   = 5'h02,
      SEQ_STATE2   = 5'h04,
      SEQ_STATE3   = 5'h08,
      SEQ_FINAL    = 5'h10
   } dbc_seq_type;

   // One observed processor access.
   typedef struct packed {
      logic [23:0] addr;
      logic [31:0] data;
      logic        rd;
      logic        valid;
   } dbc_access_type;

endpackage

// [hw/dbc_debug_monitor.sv]
// Debug event flags, sequencer status and comparator A with APB access.
// How it works
// - Non-trigger flags set only while the session arm is already set.
// - Trigger flag sets when armed or in the very arming cycle.
// - Flags clear only on arming, so they survive session end.
// - Any number of flags may set together; none blocks another.
// - Read-only flags: trigger bit6, external bit4, matches bits 3..0.
// - State field follows each sequencer transition during a session.
// - Software disarm keeps the last state in the field.
// - Internal session end returns to disarmed and clears the field.
// - Arming enters state one and forces the field to 001.
// - Codes: 000 disarmed, 001-011 states, 100 final, rest reserved.
// - Comparator registers read anytime; writes ignored while armed.
// - Inversion bit6 picks equality or difference; ignored under instruction_select.
// - Instruction select bit5 chooses data address or program counter.
// - Direction enable bit2, value bit3 writes/reads; ignored under instruction_select.
// - Comparator enable bit0 gates every comparator A match.
// - All 24 address bits compare against the three address bytes.
// - Compare data is four bytes, most significant byte first.
// - A data bit compares only when its mask bit is one.
// - Mask register is four bytes; zero excludes, one includes a bit.
// - Range mapping uses comparator A control bits for the range.
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps

module dbc_debug_monitor
   import dbc_pkg::*;
#(
   parameter int ADDR_W = 24
)(
   input  wire logic           clk_sys,
   input  wire logic           rst_n,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [11:0]    paddr,
   input  wire logic [31:0]    pwdata,
   output logic     [31:0]     prdata,
   output logic                pready,
   output logic                pslverr,
   input  wire dbc_access_type data_access,
   input  wire dbc_access_type pc_access,
   input  wire logic [23:0]    range_upper_addr,
   input  wire logic           trigger_event,
   input  wire logic           external_event_pin,
   input  wire logic [3:1]     channel_match,
   input  wire logic           seq_goto_valid,
   input  wire logic [2:0]     seq_goto_code,
   input  wire logic           session_end_event,
   output logic                armed,
   output logic                match_a,
   output logic [2:0]          sequencer_state_field
);

   // ************************************************************
   // Elaboration check.
   // ************************************************************
   if (ADDR_W != 24) begin : g_width_check
      $error("Comparator address width must be 24.");
   end

   // ************************************************************
   // Storage.
   // ************************************************************
   logic [7:0]  comparator_a_control;
   logic [23:0] compare_address;
   logic [31:0] compare_data;
   logic [31:0] compare_data_mask;
   logic [1:0]  comparator_mapping;
   logic [6:0]  event_flags;
   dbc_seq_type seq_state;
   logic [2:0]  ext_sync;
   logic        ext_level;

   // ************************************************************
   // APB decode.
   // ************************************************************
   wire [9:0] idx          = paddr[11:2];
   wire       setup_phase  = psel && !penable;
   wire       write_done   = psel && penable && pready && pwrite;
   wire       in_data      = idx >= IDX_CMPA_DATA0 && idx <= IDX_CMPA_DATA3;
   wire       in_mask      = idx >= IDX_CMPA_MASK0 && idx <= IDX_CMPA_MASK3;
   wire [1:0] byte_sel     = idx[1:0];
   wire       hit_ctrl     = idx == IDX_SESSION_CTRL;
   wire       hit_map      = idx == IDX_MAPPING;
   wire       hit_flags    = idx == IDX_EVENT_FLAGS;
   wire       hit_status   = idx == IDX_SEQ_STATUS;
   wire       hit_cctl     = idx == IDX_CMPA_CTRL;
   wire       hit_ahi      = idx == IDX_CMPA_ADDR_HI;
   wire       hit_amd      = idx == IDX_CMPA_ADDR_MD;
   wire       hit_alo      = idx == IDX_CMPA_ADDR_LO;
   wire       mapped       = hit_ctrl || hit_map || hit_flags || hit_status ||
                             hit_cctl || hit_ahi || hit_amd || hit_alo ||
                             in_data || in_mask;
   wire       unaligned    = paddr[1:0] != 2'h0;
   wire       bad_access   = !mapped || unaligned;
   wire       good_write   = write_done && !pslverr;
   wire       cfg_write    = good_write && !armed;

   // Byte lane of a 32-bit field; byte 0 is the most significant.
   wire [4:0] lane_shift   = {~byte_sel, 3'h0};
   wire [31:0] lane_mask   = 32'h0000_00FF << lane_shift;
   wire [31:0] lane_data   = {24'h00_0000, pwdata[7:0]} << lane_shift;
   wire [31:0] data_rd     = compare_data >> lane_shift;
   wire [31:0] mask_rd     = compare_data_mask >> lane_shift;

   // Session arm set and cleared by software writes to the control word.
   wire sw_arm_set   = good_write && hit_ctrl && pwdata[BIT_ARM] && !armed;
   wire sw_disarm    = good_write && hit_ctrl && !pwdata[BIT_ARM] && armed;
   wire internal_end = armed && session_end_event && !sw_disarm;

   // Read multiplexer, sampled in the setup cycle.
   logic [7:0] read_byte;
   always_comb begin
      read_byte = 8'h00;
      if (hit_ctrl) begin
         read_byte = {7'h00, armed};
      end else if (hit_map) begin
         read_byte = {6'h00, comparator_mapping};
      end else if (hit_flags) begin
         read_byte = {1'b0, event_flags};
      end else if (hit_status) begin
         read_byte = {5'h00, sequencer_state_field};
      end else if (hit_cctl) begin
         read_byte = comparator_a_control;
      end else if (hit_ahi) begin
         read_byte = compare_address[23:16];
      end else if (hit_amd) begin
         read_byte = compare_address[15:8];
      end else if (hit_alo) begin
         read_byte = compare_address[7:0];
      end else if (in_data) begin
         read_byte = data_rd[7:0];
      end else if (in_mask) begin
         read_byte = mask_rd[7:0];
      end
   end

   // Answer one cycle after the setup cycle with registered data.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= RESET_WORD;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase && bad_access;
         if (setup_phase) begin
            prdata <= bad_access ? RESET_WORD : {24'h00_0000, read_byte};
         end
      end
   end

   // ************************************************************
   // Configuration registers; the flag and status words take no write.
   // ************************************************************
   // read-only ignores writes
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         comparator_a_control <= RESET_BYTE;
         compare_address      <= 24'h00_0000;
         comparator_mapping   <= MAP_DIRECT;
      end else if (cfg_write) begin
         if (hit_cctl) comparator_a_control <= pwdata[7:0];
         if (hit_ahi) compare_address[23:16] <= pwdata[7:0];
         if (hit_amd) compare_address[15:8] <= pwdata[7:0];
         if (hit_alo) compare_address[7:0] <= pwdata[7:0];
         if (hit_map) comparator_mapping <= pwdata[1:0];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         compare_data      <= RESET_WORD;
         compare_data_mask <= RESET_WORD;
      end else if (cfg_write && in_data) begin
         compare_data <= (compare_data & ~lane_mask) | lane_data;
      end else if (cfg_write && in_mask) begin
         compare_data_mask <= (compare_data_mask & ~lane_mask) | lane_data;
      end
   end

   // ************************************************************
   // Comparator A.
   // ************************************************************
   wire instruction_select_sel  = comparator_a_control[BIT_INSTRUCTION_SELECT_SEL];
   wire data_inv  = comparator_a_control[BIT_DATA_INV];
   wire dir_en    = comparator_a_control[BIT_DIR_ENABLE];
   wire dir_val   = comparator_a_control[BIT_DIR_VALUE];
   wire cmp_en    = comparator_a_control[BIT_CMP_ENABLE];
   wire [23:0] obs_addr  = instruction_select_sel ? pc_access.addr : data_access.addr;
   wire        obs_valid = instruction_select_sel ? pc_access.valid : data_access.valid;
   wire addr_equal = obs_addr == compare_address;
   wire data_equal = ((data_access.data ^ compare_data) &
                      compare_data_mask) == 32'h0000_0000;
   wire data_ok    = instruction_select_sel || (data_equal ^ data_inv);
   wire dir_ok     = instruction_select_sel || !dir_en || (data_access.rd == dir_val);
   // range mode uses comparator A qualifiers
   wire range_mode = comparator_mapping != MAP_DIRECT;
   wire in_range   = obs_addr >= compare_address &&
                     obs_addr <= range_upper_addr;
   wire range_hit  = (comparator_mapping == MAP_OUTSIDE) ? !in_range
                                                          : in_range;
   wire hit_raw    = range_mode ? range_hit : (addr_equal && data_ok);
   wire next_match = cmp_en && obs_valid && dir_ok && hit_raw;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         match_a <= 1'b0;
      end else begin
         match_a <= next_match;
      end
   end

   // ************************************************************
   // External event pin: three-stage synchroniser and rise detect.
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ext_sync  <= 3'h0;
         ext_level <= 1'b0;
      end else begin
         ext_sync <= {ext_sync[1:0], external_event_pin};
         if (ext_sync[1] == ext_sync[2]) ext_level <= ext_sync[2];
      end
   end
   wire ext_rise = (ext_sync[1] == ext_sync[2]) && ext_sync[2] && !ext_level;

   // ************************************************************
   // Arm control.
   // ************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         armed <= 1'b0;
      end else if (sw_arm_set) begin
         armed <= 1'b1;
      end else if (sw_disarm || internal_end) begin
         armed <= 1'b0;
      end
   end

   // ************************************************************
   // Event flags.
   // ************************************************************
   // gate non-trigger flags
   wire [3:0] set_match = armed ? {channel_match, match_a} : 4'h0;
   wire       set_ext   = armed && ext_rise;
   wire       set_trigger_event  = trigger_event && (armed || sw_arm_set);
   wire [6:0] set_flags = {set_trigger_event, 1'b0, set_ext, set_match};

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         event_flags <= 7'h00;
      end else if (sw_arm_set) begin
         event_flags <= set_flags;
      end else begin
         event_flags <= event_flags | set_flags;
      end
   end

   // ************************************************************
   // State sequencer and its status field.
   // ************************************************************
   logic [2:0]  goto_code_ok;
   dbc_seq_type goto_state;
   always_comb begin
      goto_code_ok = 3'h0;
      goto_state   = SEQ_STATE1;
      case (seq_goto_code)
         SSF_STATE1: begin
            goto_code_ok = SSF_STATE1;
            goto_state   = SEQ_STATE1;
         end
         SSF_STATE2: begin
            goto_code_ok = SSF_STATE2;
            goto_state   = SEQ_STATE2;
         end
         SSF_STATE3: begin
            goto_code_ok = SSF_STATE3;
            goto_state   = SEQ_STATE3;
         end
         SSF_FINAL: begin
            goto_code_ok = SSF_FINAL;
            goto_state   = SEQ_FINAL;
         end
         default: begin
            goto_code_ok = 3'h0;
            goto_state   = SEQ_STATE1;
         end
      endcase
   end
   wire seq_step = armed && !sw_disarm && !internal_end && seq_goto_valid &&
                   goto_code_ok != 3'h0;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         seq_state             <= SEQ_DISARMED;
         sequencer_state_field <= SSF_DISARMED;
      end else if (sw_arm_set) begin
         seq_state             <= SEQ_STATE1;
         sequencer_state_field <= SSF_STATE1;
      end else if (internal_end) begin
         seq_state             <= SEQ_DISARMED;
         sequencer_state_field <= SSF_DISARMED;
      end else if (sw_disarm) begin
         seq_state <= SEQ_DISARMED;
      end else if (seq_step) begin
         seq_state             <= goto_state;
         sequencer_state_field <= goto_code_ok;
      end
   end

   // ************************************************************
   // Assertions.
   // ************************************************************
   sequence s_arm_write;
      sw_arm_set;
   endsequence
   sequence s_armed_in_one;
      armed && sequencer_state_field == SSF_STATE1;
   endsequence

   property p_flags_need_arm;
      @(posedge clk_sys) disable iff (!rst_n)
      (!armed && !sw_arm_set) |=> event_flags[5:0] == $past(event_flags[5:0]);
   endproperty
   a_flags_need_arm: assert property (p_flags_need_arm)
      else $error("Flag set while not armed.");

   property p_trigger_event_on_arm;
      @(posedge clk_sys) disable iff (!rst_n)
      (sw_arm_set && trigger_event) |=> event_flags[BIT_TRIGGER_FLAG];
   endproperty
   a_trigger_event_on_arm: assert property (p_trigger_event_on_arm)
      else $error("Trigger in arming cycle lost.");

   property p_flags_keep;
      @(posedge clk_sys) disable iff (!rst_n)
      !sw_arm_set |=> (event_flags & $past(event_flags)) == $past(event_flags);
   endproperty
   a_flags_keep: assert property (p_flags_keep)
      else $error("Flag cleared without arming.");

   property p_arm_enters_one;
      @(posedge clk_sys) disable iff (!rst_n)
      s_arm_write |=> s_armed_in_one ##0 seq_state == SEQ_STATE1;
   endproperty
   a_arm_enters_one: assert property (p_arm_enters_one)
      else $error("Arming did not enter state one.");

   property p_disarm_keeps;
      @(posedge clk_sys) disable iff (!rst_n)
      sw_disarm |=> !armed && sequencer_state_field ==
                    $past(sequencer_state_field);
   endproperty
   a_disarm_keeps: assert property (p_disarm_keeps)
      else $error("Software disarm changed the state field.");

   property p_end_clears;
      @(posedge clk_sys) disable iff (!rst_n)
      internal_end |=> !armed && sequencer_state_field == SSF_DISARMED;
   endproperty
   a_end_clears: assert property (p_end_clears)
      else $error("Internal end did not clear the state field.");

   property p_no_reserved;
      @(posedge clk_sys) disable iff (!rst_n)
      sequencer_state_field <= SSF_FINAL;
   endproperty
   a_no_reserved: assert property (p_no_reserved)
      else $error("Reserved state code driven.");

   property p_locked_cfg;
      @(posedge clk_sys) disable iff (!rst_n)
      armed ##1 armed |-> $stable(comparator_a_control) &&
                          $stable(compare_address) && $stable(compare_data);
   endproperty
   a_locked_cfg: assert property (p_locked_cfg)
      else $error("Comparator setup changed while armed.");

   property p_enable_gates;
      @(posedge clk_sys) disable iff (!rst_n)
      !cmp_en |=> !match_a;
   endproperty
   a_enable_gates: assert property (p_enable_gates)
      else $error("Match produced with comparator disabled.");

   property p_match_flag;
      @(posedge clk_sys) disable iff (!rst_n)
      (armed && match_a && !sw_disarm) |=> event_flags[0];
   endproperty
   a_match_flag: assert property (p_match_flag)
      else $error("Match flag not set.");

endmodule

// [test/dbc_core_model.sv]
// Processor core model that drives the observed data and program buses.
`timescale 1ns/1ps

module dbc_core_model
   import dbc_pkg::*;
(
   input  wire logic     clk_sys,
   output dbc_access_type data_access,
   output dbc_access_type pc_access
);
   // Both buses start idle with no access marked valid.
   initial begin
      data_access = '0;
      pc_access   = '0;
   end

   // One access lasts one cycle; afterwards the bus shows inverted junk.
   task automatic access(input logic        pc,
                         input logic [23:0] addr,
                         input logic [31:0] data,
                         input logic        rd);
      dbc_access_type acc;
      acc = '{addr: addr, data: data, rd: rd, valid: 1'b1};
      @(posedge clk_sys);
      if (pc) begin
         pc_access <= acc;
      end else begin
         data_access <= acc;
      end
      @(posedge clk_sys);
      data_access <= '{addr: ~addr, data: ~data, rd: ~rd, valid: 1'b0};
      pc_access   <= '{addr: ~addr, data: ~data, rd: ~rd, valid: 1'b0};
   endtask
endmodule

// [test/testbench.sv]
// Register-level test of the debug event flags and comparator A.
`timescale 1ns/1ps

module testbench;
   import dbc_pkg::*;
   logic           clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0]    paddr;
   logic [31:0]    pwdata, prdata;
   dbc_access_type data_access, pc_access;
   logic           trigger_event, external_event_pin, seq_goto_valid;
   logic           session_end_event, armed, match_a;
   logic [3:1]     channel_match;
   logic [2:0]     seq_goto_code, sequencer_state_field;
   logic [23:0]    range_hi;
   int             err_count, tests_run;
   localparam logic [23:0] CA = 24'hABCDEF;
   localparam logic [31:0] CD = 32'h12345678;
   localparam logic [31:0] CM = 32'hFF00FF00;

   dbc_debug_monitor DUT (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .data_access(data_access), .pc_access(pc_access),
      .range_upper_addr(range_hi), .trigger_event(trigger_event),
      .external_event_pin(external_event_pin),
      .channel_match(channel_match), .seq_goto_valid(seq_goto_valid),
      .seq_goto_code(seq_goto_code), .session_end_event(session_end_event),
      .armed(armed), .match_a(match_a),
      .sequencer_state_field(sequencer_state_field));

   dbc_core_model core (.clk_sys(clk_sys), .data_access(data_access),
      .pc_access(pc_access));

   // The system clock toggles every half period of 5 ns.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ************************************************************
   // Bus, compare and report tasks.
   // ************************************************************
   task final_report;
      if (err_count == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer: setup cycle, then access until pready is sampled.
   task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
            output logic [31:0] rd, output logic er);
      int n;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         $display("CHECK FAILED t=%0t no bus answer", $time);
         final_report;
      end
   endtask

   task wr(input logic [9:0] idx, input logic [7:0] v);
      logic [31:0] d;
      logic        e;
      apb(1'b1, idx, {24'h0, v}, d, e);
   endtask

   // Reads until the expected value shows, for events crossing a synchroniser.
   task rd_chk(input logic [9:0] idx, input logic [31:0] exp);
      logic [31:0] d;
      logic        e;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, idx, 32'h0, d, e);
         if (d === exp) break;
      end
      chk(d, exp);
   endtask

   task mt(input logic [7:0] ctl, input logic pc, input logic [23:0] a,
           input logic [31:0] d, input logic r, input logic exp);
      wr(IDX_CMPA_CTRL, ctl);
      core.access(pc, a, d, r);
      #1 chk({31'h0, match_a}, {31'h0, exp});
   endtask

   task gto(input logic [2:0] code);
      @(posedge clk_sys);
      seq_goto_valid <= 1'b1;
      seq_goto_code <= code;
      @(posedge clk_sys);
      seq_goto_valid <= 1'b0;
   endtask

   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      logic [31:0] d;
      logic        e;
      err_count = 0;
      tests_run = 0;
      rst_n = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {trigger_event, external_event_pin, channel_match} = '0;
      {seq_goto_valid, seq_goto_code, session_end_event} = '0;
      range_hi = 24'hABCDFF;
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      rd_chk(IDX_EVENT_FLAGS, 32'h0);
      rd_chk(IDX_SEQ_STATUS, 32'h0);
      rd_chk(IDX_CMPA_CTRL, 32'h0);
      for (int i = 0; i < 11; i++)
         rd_chk(IDX_CMPA_ADDR_HI + i, 32'h0);
      apb(1'b0, 10'h3FF, 32'h0, d, e);
      chk({31'h0, e}, 32'h1);
      wr(IDX_CMPA_ADDR_HI, CA[23:16]);
      wr(IDX_CMPA_ADDR_MD, CA[15:8]);
      wr(IDX_CMPA_ADDR_LO, CA[7:0]);
      for (int i = 0; i < 4; i++) begin
         wr(IDX_CMPA_DATA0 + i, CD[31 - 8 * i -: 8]);
         wr(IDX_CMPA_MASK0 + i, CM[31 - 8 * i -: 8]);
      end
      for (int i = 0; i < 4; i++)
         rd_chk(IDX_CMPA_DATA0 + i, {24'h0, CD[31 - 8 * i -: 8]});
      for (int i = 0; i < 4; i++)
         rd_chk(IDX_CMPA_MASK0 + i, {24'h0, CM[31 - 8 * i -: 8]});
      rd_chk(IDX_CMPA_ADDR_MD, 32'hCD);
      mt(8'h01, 1'b0, CA, 32'h12FF56FF, 1'b0, 1'b1);
      mt(8'h01, 1'b0, CA ^ 24'h800000, CD, 1'b0, 1'b0);
      mt(8'h01, 1'b0, CA ^ 24'h000001, CD, 1'b0, 1'b0);
      mt(8'h00, 1'b0, CA, CD, 1'b0, 1'b0);
      mt(8'h01, 1'b0, CA, 32'h13345678, 1'b0, 1'b0);
      mt(8'h41, 1'b0, CA, 32'h13345678, 1'b0, 1'b1);
      mt(8'h41, 1'b0, CA, CD, 1'b0, 1'b0);
      mt(8'h05, 1'b0, CA, CD, 1'b1, 1'b0);
      mt(8'h05, 1'b0, CA, CD, 1'b0, 1'b1);
      mt(8'h0D, 1'b0, CA, CD, 1'b0, 1'b0);
      mt(8'h0D, 1'b0, CA, CD, 1'b1, 1'b1);
      mt(8'h01, 1'b0, CA, CD, 1'b1, 1'b1);
      mt(8'h21, 1'b1, CA, CD, 1'b0, 1'b1);
      mt(8'h21, 1'b0, CA, CD, 1'b0, 1'b0);
      mt(8'h6D, 1'b1, CA, 32'h0, 1'b0, 1'b1);
      // Events while disarmed must leave every flag clear.
      wr(IDX_CMPA_CTRL, 8'h01);
      @(posedge clk_sys);
      trigger_event <= 1'b1;
      channel_match <= 3'b111;
      @(posedge clk_sys);
      trigger_event <= 1'b0;
      channel_match <= 3'b000;
      core.access(1'b0, CA, CD, 1'b0);
      rd_chk(IDX_EVENT_FLAGS, 32'h0);
      // Arm with a trigger in the very arming cycle.
      @(posedge clk_sys);
      trigger_event <= 1'b1;
      wr(IDX_SESSION_CTRL, 8'h01);
      trigger_event <= 1'b0;
      rd_chk(IDX_EVENT_FLAGS, 32'h40);
      rd_chk(IDX_SEQ_STATUS, 32'h1);
      external_event_pin <= 1'b1;
      @(posedge clk_sys);
      channel_match <= 3'b111;
      @(posedge clk_sys);
      channel_match <= 3'b000;
      core.access(1'b0, CA, CD, 1'b0);
      rd_chk(IDX_EVENT_FLAGS, 32'h5F);
      wr(IDX_CMPA_CTRL, 8'h00);
      rd_chk(IDX_CMPA_CTRL, 32'h01);
      wr(IDX_EVENT_FLAGS, 8'h00);
      rd_chk(IDX_EVENT_FLAGS, 32'h5F);
      gto(3'h2);
      rd_chk(IDX_SEQ_STATUS, 32'h2);
      gto(3'h5);
      rd_chk(IDX_SEQ_STATUS, 32'h2);
      wr(IDX_SESSION_CTRL, 8'h00);
      rd_chk(IDX_SEQ_STATUS, 32'h2);
      rd_chk(IDX_EVENT_FLAGS, 32'h5F);
      wr(IDX_SESSION_CTRL, 8'h01);
      rd_chk(IDX_EVENT_FLAGS, 32'h0);
      rd_chk(IDX_SEQ_STATUS, 32'h1);
      gto(3'h4);
      rd_chk(IDX_SEQ_STATUS, 32'h4);
      @(posedge clk_sys);
      session_end_event <= 1'b1;
      @(posedge clk_sys);
      session_end_event <= 1'b0;
      rd_chk(IDX_SEQ_STATUS, 32'h0);
      chk({31'h0, armed}, 32'h0);
      chk({29'h0, sequencer_state_field}, 32'h0);
      // Range modes: inside, then outside the window CA up to range_hi.
      wr(IDX_MAPPING, 8'h01);
      mt(8'h01, 1'b0, 24'hABCDF0, 32'h0, 1'b0, 1'b1);
      mt(8'h01, 1'b0, 24'hABCDEE, CD, 1'b0, 1'b0);
      wr(IDX_MAPPING, 8'h02);
      mt(8'h01, 1'b0, 24'hABCDF0, CD, 1'b0, 1'b0);
      mt(8'h0D, 1'b0, 24'hABCDEE, CD, 1'b1, 1'b1);
      final_report;
   end
endmodule
